// >>> verilog/gpio_port.sv
// GPIO port slice: latch, direction, pad controls, filtered pin interrupts
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "gpio_consts.svh"

// Operation
// - Latch drives pin as GPIO output
// - Latch write reaches pin only when output
// - Direction 0 reads synchronized pin level
// - Direction 1 reads stored latch value
// - Pin view read-only, always pin level
// - Peripheral ownership overrides direction for drive
// - Direction still selects latch readback source
// - Readback may lag pin by two cycles
// - Reduced drive applies to any output
// - Pull active only input or wired-or
// - Wired-or output allows pull-up only
// - Wired-or disables high-side drive
// - Mask gates each flag
// - Filtered edge of chosen polarity sets flag
// - Per-pin enable, edge; shared request
// - Request when flag and mask set
// - Enabled pin interrupt wakes STOP/WAIT
// - Three-clock pulses ignored, four accepted
// - Four passive then four active samples
// - Filter on bus clock, RC in STOP
// - RC runs while count<=4, enabled, clear
// - Polarity bit picks pull and edge
module gpio_port
  import gpio_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             psel_in,
  input  wire logic             penable_in,
  input  wire logic             pwrite_in,
  input  wire logic [11:0]      paddr_in,
  input  wire logic [31:0]      pwdata_in,
  output logic      [31:0]      prdata_out,
  output logic                  pready_out,
  output logic                  pslverr_out,
  input  wire logic [WIDTH-1:0] pin_in,
  input  wire logic [WIDTH-1:0] periph_own_in,
  input  wire logic [WIDTH-1:0] periph_out_in,
  input  wire logic [WIDTH-1:0] periph_oe_in,
  input  wire logic             stop_mode_in,
  input  wire logic             wait_mode_in,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe_out,
  output logic      [WIDTH-1:0] drive_reduced_out,
  output logic      [WIDTH-1:0] pull_up_en_out,
  output logic      [WIDTH-1:0] pull_down_en_out,
  output logic                  irq_out,
  output logic                  wakeup_out,
  output logic                  rc_osc_run_out
);

  // Read data and status bits share one 32-bit word
  if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
    $error("gpio_port: WIDTH must be 1..32");
  end

  // Register state
  logic [WIDTH-1:0] port_output_latch_q;
  logic [WIDTH-1:0] direction_bits_q;
  logic [WIDTH-1:0] drive_strength_select_q;
  logic [WIDTH-1:0] pull_enable_bits_q;
  logic [WIDTH-1:0] pull_polarity_select_q;
  logic [WIDTH-1:0] open_drain_select_q;
  logic [WIDTH-1:0] pin_irq_mask_q;
  logic [WIDTH-1:0] pin_irq_flag_q;
  logic [WIDTH-1:0] pin_irq_flag_d;
  logic [WIDTH-1:0] sync1_q;
  logic [WIDTH-1:0] pin_level_view_q;
  logic [WIDTH-1:0] edge_hit;
  logic [WIDTH-1:0] rc_need;
  gpio_power_type   power_mode;

  // APB decode
  wire acc_phase = psel_in & penable_in;
  wire wr_en     = acc_phase & pwrite_in;
  wire hit_latch   = (paddr_in == `GPIO_OFF_LATCH);
  wire hit_view    = (paddr_in == `GPIO_OFF_VIEW);
  wire hit_dir     = (paddr_in == `GPIO_OFF_DIR);
  wire hit_drive   = (paddr_in == `GPIO_OFF_DRIVE);
  wire hit_pullen  = (paddr_in == `GPIO_OFF_PULLEN);
  wire hit_pullpol = (paddr_in == `GPIO_OFF_PULLPOL);
  wire hit_odrain  = (paddr_in == `GPIO_OFF_ODRAIN);
  wire hit_irqmask = (paddr_in == `GPIO_OFF_IRQMASK);
  wire hit_irqflag = (paddr_in == `GPIO_OFF_IRQFLAG);
  wire hit_periph  = (paddr_in == `GPIO_OFF_PERIPH);
  wire hit_status  = (paddr_in == `GPIO_OFF_STATUS);
  wire hit_any = hit_latch | hit_view | hit_dir | hit_drive | hit_pullen | hit_pullpol
               | hit_odrain | hit_irqmask | hit_irqflag | hit_periph | hit_status;
  wire [WIDTH-1:0] wdata = pwdata_in[WIDTH-1:0];

  // input bits read pin, output bits read latch, regardless of owner
  wire [WIDTH-1:0] latch_readback =
    (direction_bits_q & port_output_latch_q) | (~direction_bits_q & pin_level_view_q);

  logic [31:0] rdata_mux;
  always_comb begin
    rdata_mux = 32'h0000_0000;
    if (hit_latch) begin
      rdata_mux[WIDTH-1:0] = latch_readback;
    end else if (hit_view) begin
      // pure view of the synchronized pin
      rdata_mux[WIDTH-1:0] = pin_level_view_q;
    end else if (hit_dir) begin
      rdata_mux[WIDTH-1:0] = direction_bits_q;
    end else if (hit_drive) begin
      rdata_mux[WIDTH-1:0] = drive_strength_select_q;
    end else if (hit_pullen) begin
      rdata_mux[WIDTH-1:0] = pull_enable_bits_q;
    end else if (hit_pullpol) begin
      rdata_mux[WIDTH-1:0] = pull_polarity_select_q;
    end else if (hit_odrain) begin
      rdata_mux[WIDTH-1:0] = open_drain_select_q;
    end else if (hit_irqmask) begin
      rdata_mux[WIDTH-1:0] = pin_irq_mask_q;
    end else if (hit_irqflag) begin
      rdata_mux[WIDTH-1:0] = pin_irq_flag_q;
    end else if (hit_periph) begin
      rdata_mux[WIDTH-1:0] = periph_own_in;
    end else if (hit_status) begin
      rdata_mux[1:0] = power_mode;
    end
  end

  // Every access completes in one access cycle; prdata/pslverr registered for flop outputs
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prdata_out  <= 32'h0000_0000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= psel_in & ~penable_in;
      pslverr_out <= psel_in & ~penable_in & ~hit_any;
      prdata_out  <= (psel_in & ~penable_in & ~pwrite_in) ? rdata_mux : 32'h0000_0000;
    end
  end

  wire wr_take = wr_en & pready_out & hit_any;

  // Per-register write strobes
  wire wr_latch   = wr_take & hit_latch;
  wire wr_dir     = wr_take & hit_dir;
  wire wr_drive   = wr_take & hit_drive;
  wire wr_pullen  = wr_take & hit_pullen;
  wire wr_pullpol = wr_take & hit_pullpol;
  wire wr_odrain  = wr_take & hit_odrain;
  wire wr_irqmask = wr_take & hit_irqmask;

  // latch write only stores, drive logic decides the pin
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      port_output_latch_q <= '0;
    end else if (wr_latch) begin
      port_output_latch_q <= wdata;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      direction_bits_q <= '0;
    end else if (wr_dir) begin
      direction_bits_q <= wdata;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      drive_strength_select_q <= '0;
    end else if (wr_drive) begin
      drive_strength_select_q <= wdata;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pull_enable_bits_q <= '0;
    end else if (wr_pullen) begin
      pull_enable_bits_q <= wdata;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pull_polarity_select_q <= '0;
    end else if (wr_pullpol) begin
      pull_polarity_select_q <= wdata;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      open_drain_select_q <= '0;
    end else if (wr_odrain) begin
      open_drain_select_q <= wdata;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_irq_mask_q <= '0;
    end else if (wr_irqmask) begin
      pin_irq_mask_q <= wdata;
    end
  end

  // two-flop synchronizer; readback lags the pin by two clocks
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1_q          <= '0;
      pin_level_view_q <= '0;
    end else begin
      sync1_q          <= pin_in;
      pin_level_view_q <= sync1_q;
    end
  end

  assign power_mode = stop_mode_in ? GPIO_MODE_STOP : (wait_mode_in ? GPIO_MODE_WAIT : GPIO_MODE_RUN);

  // Per-pin pad control and glitch filter
  logic [WIDTH-1:0] pin_d;
  logic [WIDTH-1:0] oe_d;
  logic [WIDTH-1:0] pu_d;
  logic [WIDTH-1:0] pd_d;
  logic [WIDTH-1:0] rd_d;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_pin
      logic [2:0] cnt_q;
      logic       prev_q;
      logic       armed_q;
      // peripheral ownership replaces direction for drive
      wire is_out  = periph_own_in[g] ? periph_oe_in[g] : direction_bits_q[g];
      // latch supplies the GPIO output level
      wire out_val = periph_own_in[g] ? periph_out_in[g] : port_output_latch_q[g];
      wire wired   = open_drain_select_q[g] & is_out;
      assign oe_d[g]  = is_out & ~(wired & out_val);
      assign pin_d[g] = out_val & ~wired;
      assign rd_d[g]  = is_out & drive_strength_select_q[g];
      // pull only as input or wired-or, polarity, wired-or forces up
      wire pull_on = pull_enable_bits_q[g] & (~is_out | wired);
      assign pu_d[g] = pull_on & (wired | ~pull_polarity_select_q[g]);
      assign pd_d[g] = pull_on & ~wired & pull_polarity_select_q[g];

      // active level is high for polarity 1 (rising), low for 0 (falling)
      wire active = ~(pin_level_view_q[g] ^ pull_polarity_select_q[g]);
      // four equal samples confirm a level; an edge needs passive then active
      wire same   = (active == prev_q);
      wire fourth = same && (cnt_q == `GPIO_FILT_SAMPLES - `GPIO_FILT_ONE);
      // fourth active sample after an armed passive run is the edge
      assign edge_hit[g] = fourth & active & armed_q;
      // oscillator demand per pin; a count past four means the pin has settled
      assign rc_need[g] = (cnt_q <= `GPIO_FILT_SAMPLES) & pin_irq_mask_q[g] & ~pin_irq_flag_q[g];

      // runs on the bus clock; the STOP RC clock is outside this slice
      always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          cnt_q   <= `GPIO_FILT_ZERO;
          prev_q  <= 1'b0;
          armed_q <= 1'b0;
        end else begin
          prev_q <= active;
          if (!same) begin
            cnt_q <= `GPIO_FILT_ONE;
          end else if (cnt_q != `GPIO_FILT_SETTLED) begin
            cnt_q <= cnt_q + `GPIO_FILT_ONE;
          end
          // Passive run arms; active run fires once and disarms, glitches in between are harmless
          if (fourth) begin
            armed_q <= ~active;
          end
        end
      end
    end
  endgenerate

  // filtered edge sets flag; write one clears; set wins over clear
  always_comb begin
    pin_irq_flag_d = pin_irq_flag_q;
    if (wr_take && hit_irqflag) begin
      pin_irq_flag_d = pin_irq_flag_q & ~wdata;
    end
    pin_irq_flag_d = pin_irq_flag_d | edge_hit;
  end

  // masked flags merge onto one request
  wire irq_d  = |(pin_irq_flag_d & pin_irq_mask_q);
  // wake from low power on any enabled request
  wire wake_d = (power_mode != GPIO_MODE_RUN) & irq_d;
  // oscillator only in STOP and only while some pin needs sampling
  wire rc_d   = (power_mode == GPIO_MODE_STOP) & |rc_need;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_irq_flag_q <= '0;
    end else begin
      pin_irq_flag_q <= pin_irq_flag_d;
    end
  end

  // Pad controls leave on flops so the pads never see decode glitches
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_out <= '0;
    end else begin
      pin_out <= pin_d;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_oe_out <= '0;
    end else begin
      pin_oe_out <= oe_d;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      drive_reduced_out <= '0;
    end else begin
      drive_reduced_out <= rd_d;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pull_up_en_out <= '0;
    end else begin
      pull_up_en_out <= pu_d;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pull_down_en_out <= '0;
    end else begin
      pull_down_en_out <= pd_d;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= irq_d;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wakeup_out <= 1'b0;
    end else begin
      wakeup_out <= wake_d;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rc_osc_run_out <= 1'b0;
    end else begin
      rc_osc_run_out <= rc_d;
    end
  end

endmodule

// >>> verilog/gpio_consts.svh
// Register offsets, reset values and timing counts for the GPIO port slice
`ifndef GPIO_CONSTS_SVH
`define GPIO_CONSTS_SVH
`define GPIO_OFF_LATCH    12'h000
`define GPIO_OFF_VIEW     12'h004
`define GPIO_OFF_DIR      12'h008
`define GPIO_OFF_DRIVE    12'h00C
`define GPIO_OFF_PULLEN   12'h010
`define GPIO_OFF_PULLPOL  12'h014
`define GPIO_OFF_ODRAIN   12'h018
`define GPIO_OFF_IRQMASK  12'h01C
`define GPIO_OFF_IRQFLAG  12'h020
`define GPIO_OFF_PERIPH   12'h024
`define GPIO_OFF_STATUS   12'h028
`define GPIO_RESET_BYTE   8'h00
`define GPIO_FILT_SAMPLES 3'h4
`define GPIO_FILT_ZERO    3'h0
`define GPIO_FILT_ONE     3'h1
// One past the confirm point: the pin has settled and needs no more sampling
`define GPIO_FILT_SETTLED 3'h5
`endif

// >>> verilog/gpio_pkg.sv
// Types shared by the GPIO port slice
package gpio_pkg;
  typedef enum logic [1:0] {
    GPIO_MODE_RUN,
    GPIO_MODE_WAIT,
    GPIO_MODE_STOP
  } gpio_power_type;
endpackage

// >>> testbench/gpio_port_props.sv
// Port-level assertions for the GPIO port slice
`timescale 1ns/1ps
`include "gpio_consts.svh"
module gpio_port_props #(
  parameter int WIDTH = 8
) (
  input wire logic             sys_clk_in,
  input wire logic             reset_n_in,
  input wire logic             psel_in,
  input wire logic             penable_in,
  input wire logic             pwrite_in,
  input wire logic [11:0]      paddr_in,
  input wire logic [31:0]      prdata_out,
  input wire logic             pready_out,
  input wire logic             pslverr_out,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic             stop_mode_in,
  input wire logic             wait_mode_in,
  input wire logic [WIDTH-1:0] pull_up_en_out,
  input wire logic [WIDTH-1:0] pull_down_en_out,
  input wire logic             irq_out,
  input wire logic             wakeup_out,
  input wire logic             rc_osc_run_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  a_ready_access: assert property (psel_in && !penable_in |=> pready_out) else $error("no pready in access");
  a_ready_single: assert property (pready_out |=> !pready_out) else $error("pready held too long");
  a_err_ready: assert property (pslverr_out |-> pready_out) else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0000_0000) else $error("read data outside access");
  a_upper_zero: assert property (prdata_out[31:WIDTH] == '0) else $error("upper read bits set");
  a_pull_exclusive: assert property (!(|(pull_up_en_out & pull_down_en_out))) else $error("both pulls on");
  // Pin view only checked once the synchronizer has settled on a steady pin
  a_view_read: assert property (pready_out && !pwrite_in && paddr_in == `GPIO_OFF_VIEW && $stable(pin_in) &&
    $past(pin_in, 2) == pin_in && $past(pin_in, 3) == pin_in |-> prdata_out[WIDTH-1:0] == pin_in) else $error("bad view");
  a_wake_mode: assert property (wakeup_out |-> irq_out && $past(stop_mode_in || wait_mode_in)) else $error("bad wakeup");
  a_rc_stop: assert property (rc_osc_run_out |-> $past(stop_mode_in)) else $error("rc request outside stop");
  c_irq: cover property (irq_out);
  c_wake: cover property (wakeup_out);
  c_rc: cover property (rc_osc_run_out);
endmodule
bind gpio_port gpio_port_props #(.WIDTH(WIDTH)) gpio_port_props_i (.*);

// >>> testbench/gpio_pin_model.sv
// Board-side pin model: resolves drive, external source and pulls
`timescale 1ns/1ps
module gpio_pin_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] oe_in,
  input  wire logic [7:0] lvl_in,
  input  wire logic [7:0] pu_in,
  input  wire logic [7:0] pd_in,
  input  wire logic [7:0] ext_en_in,
  input  wire logic [7:0] ext_lvl_in,
  output logic      [7:0] pin_out
);
  logic [7:0] float_q = 8'h00;
  // Undriven, unpulled lines wander so a stale level is never mistaken for valid
  always_ff @(posedge clk_in) float_q <= ~float_q;
  assign pin_out = (oe_in & lvl_in) | (~oe_in & ext_en_in & ext_lvl_in) |
                   (~oe_in & ~ext_en_in & (pu_in | (~pd_in & float_q)));
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench for the GPIO port slice
`timescale 1ns/1ps
`include "gpio_consts.svh"
module tb_top;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e; logic er;} gpio_row_type;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, stop = 0, wmode = 0, ready, err, errq, irq, wake, rc;
  logic [11:0] addr = 0;
  logic [31:0] wd = 0, rdata, rq;
  logic [7:0] own = 0, pout = 0, poe = 0, ext = 8'h96, pin, po, oe, drv, pu, pd;
  int n_mismatch = 0, num_checks = 0;
  gpio_row_type rows [8] = '{'{`GPIO_OFF_DRIVE, 32'hFFFF_FFA5, 32'h0000_00A5, 0}, '{`GPIO_OFF_PULLEN, 32'h3C, 32'h3C, 0},
    '{`GPIO_OFF_PULLPOL, 32'h0F, 32'h0F, 0}, '{`GPIO_OFF_ODRAIN, 32'hF0, 32'hF0, 0}, '{`GPIO_OFF_IRQMASK, 32'h81, 32'h81, 0},
    '{`GPIO_OFF_VIEW, 32'hFF, 32'h96, 0}, '{`GPIO_OFF_LATCH, 32'h5A, 32'h96, 0}, '{12'h030, 32'h1, 32'h0, 1}};
  always #4 clk = ~clk;
  gpio_port gpio_port_i (.sys_clk_in(clk), .reset_n_in(rst_n), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(addr), .pwdata_in(wd), .prdata_out(rdata), .pready_out(ready), .pslverr_out(err), .pin_in(pin),
    .periph_own_in(own), .periph_out_in(pout), .periph_oe_in(poe), .stop_mode_in(stop), .wait_mode_in(wmode),
    .pin_out(po), .pin_oe_out(oe), .drive_reduced_out(drv), .pull_up_en_out(pu), .pull_down_en_out(pd),
    .irq_out(irq), .wakeup_out(wake), .rc_osc_run_out(rc));
  gpio_pin_model gpio_pin_model_i (.clk_in(clk), .oe_in(oe), .lvl_in(po), .pu_in(pu), .pd_in(pd),
    .ext_en_in(8'hFF), .ext_lvl_in(ext), .pin_out(pin));
  task automatic end_sim;
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1; pen <= 0; pwr <= w; addr <= a; wd <= d;
    @(posedge clk);
    pen <= 1;
    n = 0;
    do begin @(posedge clk); n++; end while (ready !== 1'b1 && n < 20);
    if (n >= 20) begin n_mismatch++; end_sim(); end
    rq = rdata;
    errq = err;
    psel <= 0;
    pen <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(rq, e);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    for (int i = 0; i < 8; i++) begin
      apb(1, rows[i].a, rows[i].d);
      apb(0, rows[i].a, 0);
      chk(rq, rows[i].e);
      chk(errq, rows[i].er);
    end
    chk(pu, 8'h30);
    chk(pd, 8'h0C);
    // Latch already holds 0x5A before the pins turn to outputs
    apb(1, `GPIO_OFF_DIR, 8'hFF);
    repeat (2) @(posedge clk);
    chk(oe, 8'hAF);
    chk(po & oe, 8'h0A);
    chk({pu, pd}, 16'h3000);
    rd(`GPIO_OFF_LATCH, 8'h5A);
    own <= 8'hFF; poe <= 8'hFF; pout <= 8'h3C;
    apb(1, `GPIO_OFF_ODRAIN, 0);
    apb(1, `GPIO_OFF_DIR, 0);
    repeat (2) @(posedge clk);
    chk({po, oe}, 16'h3CFF);
    chk(drv, 8'hA5);
    rd(`GPIO_OFF_LATCH, 8'h3C);
    // Pins settle on the external levels before the flags are cleared
    own <= 0; poe <= 0;
    repeat (8) @(posedge clk);
    apb(1, `GPIO_OFF_IRQFLAG, 8'hFF);
    repeat (8) @(posedge clk);
    ext <= 8'h97;
    repeat (3) @(posedge clk);
    ext <= 8'h96;
    repeat (10) @(posedge clk);
    rd(`GPIO_OFF_IRQFLAG, 0);
    ext <= 8'h17;
    repeat (10) @(posedge clk);
    rd(`GPIO_OFF_IRQFLAG, 8'h81);
    chk(irq, 1);
    wmode <= 1;
    repeat (2) @(posedge clk);
    chk(wake, 1);
    wmode <= 0;
    apb(1, `GPIO_OFF_IRQMASK, 8'h01);
    apb(1, `GPIO_OFF_IRQFLAG, 8'h01);
    rd(`GPIO_OFF_IRQFLAG, 8'h80);
    chk(irq, 0);
    stop <= 1;
    repeat (2) @(posedge clk);
    chk(rc, 0);
    ext <= 8'h16;
    repeat (5) @(posedge clk);
    chk(rc, 1);
    stop <= 0;
    end_sim();
  end
endmodule
